// ==== hw/timer16_defs.vh ====
// Constants for the 16-bit timer core: register offsets, field
// positions, reset values and prescaler taps.
// Assumes a classic Wishbone slave with byte data in lane 0.
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH

// Word-aligned byte offsets
`define OFS_CONTROL_A 8'h00
`define OFS_CONTROL_B 8'h04
`define OFS_CONTROL_C 8'h08
`define OFS_COUNT_LOW 8'h0C
`define OFS_COUNT_HIGH 8'h10
`define OFS_CAPTURE_LOW 8'h14
`define OFS_CAPTURE_HIGH 8'h18
`define OFS_COMPARE_A_LOW 8'h1C
`define OFS_COMPARE_A_HIGH 8'h20
`define OFS_COMPARE_B_LOW 8'h24
`define OFS_COMPARE_B_HIGH 8'h28
`define OFS_FLAG 8'h2C
`define OFS_MASK 8'h30

// Reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000

// Control A fields
`define CA_OUT_A 7:6
`define CA_OUT_B 5:4
`define CA_MODE_LO 1:0
// Control B fields
`define CB_FILTER 7
`define CB_EDGE 6
`define CB_MODE_HI 4:3
`define CB_CLOCK_SEL 2:0

// Flag and mask bit positions
`define FL_CAPTURE 5
`define FL_CMP_B 2
`define FL_CMP_A 1
`define FL_OVERFLOW 0
`define FLAG_USED 8'h27

// Clock select codes
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7

// Prescaler tap masks on a 10-bit free-running divider
`define PRE_W 10
`define PRE_M8 10'h007
`define PRE_M64 10'h03F
`define PRE_M256 10'h0FF
`define PRE_M1024 10'h3FF

// Fixed ceilings
`define TOP_8 16'h00FF
`define TOP_9 16'h01FF
`define TOP_10 16'h03FF
`define TOP_MAX 16'hFFFF

// Noise filter sample count
`define FILTER_SAMPLES 4

`endif

// ==== hw/edge_sense.v ====
// Edge detector with optional majority-free noise filter: the
// filtered level only moves after FILTER_LEN equal samples.
// Assumes sig_i is synchronous to clk_i.
`timescale 1ns/10ps
`include "timer16_defs.vh"

module edge_sense #(
    parameter FILTER_LEN = `FILTER_SAMPLES
) (
    input wire clk_i,
    input wire rst_i,
    input wire sig_i,
    input wire filter_en_i,
    input wire rising_i,
    output wire edge_o
);
    reg [FILTER_LEN-1:0] hist;
    reg filt;
    reg prev;
    wire level;

    // Sample history and filtered level
    always @(posedge clk_i) begin
        if (rst_i) begin
            hist <= {FILTER_LEN{1'b0}};
            filt <= 1'b0;
            prev <= 1'b0;
        end else begin
            hist <= {hist[FILTER_LEN-2:0], sig_i};
            if (&hist)
                filt <= 1'b1;
            else if (~|hist)
                filt <= 1'b0;
            prev <= level;
        end
    end

    // Filter adds its sample delay only when enabled
    assign level = filter_en_i ? filt : hist[0];
    assign edge_o = rising_i ? (level & ~prev) : (~level & prev);

endmodule // edge_sense

// ==== hw/timer16_core.v ====
// 16-bit timer/counter core behind a classic Wishbone slave.
// Byte registers sit in bits 7:0 of one aligned word each.
// Assumes synchronous inputs and a single 125 MHz system clock.
//
// Overview of operation
// - 16-bit registers reached as two byte accesses
// - One shared 8-bit high-byte holding register
// - Low write loads holding byte plus data
// - Counter and capture low reads copy high byte into holding
// - Compare high reads bypass the holding register
// - Counter high location is the holding register
// - Holding register survives low-byte writes
// - Clock select picks source; zero stops
// - Counter accessible whether or not clocked
// - Software write beats clear and count
// - Each tick clears, increments or decrements
// - Ceiling and floor indications from counter
// - Mode field split across controls A, B
// - Overflow flag point depends on mode
// - Compare matches set flags, drive pins
// - Ceiling from compare A, capture, fixed
// - Each request flagged and individually masked
// - Capture on selected edge, optional filter
// - Control registers accessed directly in one go
`timescale 1ns/10ps
`include "timer16_defs.vh"

module timer16_core (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    input wire external_count_pin_i,
    input wire capture_pin_i,
    input wire comparator_i,
    input wire comparator_sel_i,
    output reg compare_output_a_o,
    output reg compare_output_b_o,
    output wire ceiling_o,
    output wire count_floor_o,
    output wire [3:0] request_o
);
    reg [7:0] timer_control_a;
    reg [7:0] timer_control_b;
    reg [7:0] timer_control_c;
    reg [7:0] timer_flag_reg;
    reg [7:0] timer_mask_reg;
    reg [7:0] holding;
    reg [15:0] count_value;
    reg [15:0] capture_value;
    reg [15:0] compare_value_a;
    reg [15:0] compare_value_b;
    reg [15:0] buffer_a;
    reg [15:0] buffer_b;
    reg count_down;
    reg [`PRE_W-1:0] prescale;
    reg [15:0] top;
    reg timer_tick;
    reg [15:0] next_count;
    reg next_down;
    reg [7:0] rd_byte;

    wire access;
    wire wr;
    wire rd;
    wire [7:0] wbyte;
    wire [3:0] waveform_mode_field;
    wire [2:0] clock_sel;
    wire ext_edge;
    wire cap_edge;
    wire dual_slope;
    wire pwm_mode;
    wire cap_is_top;
    wire a_is_top;
    wire at_top;
    wire at_floor;
    wire match_a;
    wire match_b;
    wire overflow_evt;
    wire cmp_a_evt;
    wire cmp_b_evt;
    wire cap_evt;
    wire wr_count;
    wire [7:0] set_flags;

    // Access is taken in the cycle before ack rises
    assign access = cyc_i & stb_i & ~ack_o;
    assign wr = access & we_i & sel_i[0];
    assign rd = access & ~we_i;
    assign wbyte = dat_i[7:0];

    // Mode field is split over two control registers
    assign waveform_mode_field = {timer_control_b[`CB_MODE_HI],
        timer_control_a[`CA_MODE_LO]};
    assign clock_sel = timer_control_b[`CB_CLOCK_SEL];

    // Mode decode: dual-slope, PWM and ceiling source
    assign dual_slope = (waveform_mode_field >= 4'h1 &&
        waveform_mode_field <= 4'h3) ||
        (waveform_mode_field >= 4'h8 &&
        waveform_mode_field <= 4'hB);
    assign pwm_mode = waveform_mode_field != 4'h0 &&
        waveform_mode_field != 4'h4 &&
        waveform_mode_field != 4'hC;
    assign cap_is_top = waveform_mode_field == 4'h8 ||
        waveform_mode_field == 4'hA ||
        waveform_mode_field == 4'hC ||
        waveform_mode_field == 4'hE;
    assign a_is_top = waveform_mode_field == 4'h4 ||
        waveform_mode_field == 4'h9 ||
        waveform_mode_field == 4'hB ||
        waveform_mode_field == 4'hF;

    // Ceiling source per mode
    always @* begin
        case (waveform_mode_field)
            4'h1, 4'h5: top = `TOP_8;
            4'h2, 4'h6: top = `TOP_9;
            4'h3, 4'h7: top = `TOP_10;
            4'h4, 4'h9, 4'hB, 4'hF: top = compare_value_a;
            4'h8, 4'hA, 4'hC, 4'hE: top = capture_value;
            default: top = `TOP_MAX;
        endcase
    end

    // External pin edge, no filter on the count input
    edge_sense #(
        .FILTER_LEN(`FILTER_SAMPLES)
    ) u_ext_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(external_count_pin_i),
        .filter_en_i(1'b0),
        .rising_i(clock_sel == `CS_EXT_RISE),
        .edge_o(ext_edge)
    );

    // Capture trigger: pin or comparator, optional filter
    edge_sense #(
        .FILTER_LEN(`FILTER_SAMPLES)
    ) u_cap_edge (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sig_i(comparator_sel_i ? comparator_i : capture_pin_i),
        .filter_en_i(timer_control_b[`CB_FILTER]),
        .rising_i(timer_control_b[`CB_EDGE]),
        .edge_o(cap_edge)
    );

    // Free-running prescaler feeding the clock select
    always @(posedge clk_i) begin
        if (rst_i)
            prescale <= {`PRE_W{1'b0}};
        else
            prescale <= prescale + 1'b1;
    end

    // Timer tick from the selected source; zero stops it
    always @* begin
        case (clock_sel)
            `CS_DIV1: timer_tick = 1'b1;
            `CS_DIV8: timer_tick = (prescale & `PRE_M8) == `PRE_M8;
            `CS_DIV64: timer_tick = (prescale & `PRE_M64) == `PRE_M64;
            `CS_DIV256: timer_tick = (prescale & `PRE_M256) ==
                `PRE_M256;
            `CS_DIV1024: timer_tick = prescale == `PRE_M1024;
            `CS_EXT_FALL, `CS_EXT_RISE: timer_tick = ext_edge;
            default: timer_tick = 1'b0;
        endcase
    end

    // Ceiling and floor indications
    assign at_top = count_value == top;
    assign at_floor = count_value == `RST_WORD;
    assign ceiling_o = at_top;
    assign count_floor_o = at_floor;

    // Next count: clear at ceiling, or turn round in dual slope
    always @* begin
        next_count = count_value;
        next_down = count_down;
        if (dual_slope) begin
            if (at_top) begin
                next_down = 1'b1;
                next_count = count_value - 16'h0001;
            end else if (at_floor) begin
                next_down = 1'b0;
                next_count = count_value + 16'h0001;
            end else if (count_down) begin
                next_count = count_value - 16'h0001;
            end else begin
                next_count = count_value + 16'h0001;
            end
        end else if (at_top) begin
            next_count = `RST_WORD;
        end else begin
            next_count = count_value + 16'h0001;
        end
    end

    // Events; overflow at ceiling for single slope, floor for dual
    assign match_a = count_value == compare_value_a;
    assign match_b = count_value == compare_value_b;
    assign overflow_evt = timer_tick & (dual_slope ? at_floor :
        at_top);
    assign cmp_a_evt = timer_tick & match_a;
    assign cmp_b_evt = timer_tick & match_b;
    assign cap_evt = cap_edge & ~cap_is_top;
    assign wr_count = wr && adr_i == `OFS_COUNT_LOW;
    assign set_flags = {2'b00, cap_evt, 2'b00, cmp_b_evt, cmp_a_evt,
        overflow_evt};

    // Counter: software write has priority over counting
    always @(posedge clk_i) begin
        if (rst_i) begin
            count_value <= `RST_WORD;
            count_down <= 1'b0;
        end else if (wr_count) begin
            count_value <= {holding, wbyte};
        end else if (timer_tick) begin
            count_value <= next_count;
            count_down <= next_down;
        end
    end

    // Capture register: edge snapshot, or software write while capture is the ceiling
    always @(posedge clk_i) begin
        if (rst_i)
            capture_value <= `RST_WORD;
        else if (wr && adr_i == `OFS_CAPTURE_LOW && cap_is_top)
            capture_value <= {holding, wbyte};
        else if (cap_evt)
            capture_value <= count_value;
    end

    // Compare buffers; PWM modes reload the active value at the
    // turn point so a pulse is never cut short
    always @(posedge clk_i) begin
        if (rst_i) begin
            buffer_a <= `RST_WORD;
            buffer_b <= `RST_WORD;
            compare_value_a <= `RST_WORD;
            compare_value_b <= `RST_WORD;
        end else begin
            if (wr && adr_i == `OFS_COMPARE_A_LOW)
                buffer_a <= {holding, wbyte};
            if (wr && adr_i == `OFS_COMPARE_B_LOW)
                buffer_b <= {holding, wbyte};
            if (!pwm_mode) begin
                compare_value_a <= buffer_a;
                compare_value_b <= buffer_b;
            end else if (timer_tick && (dual_slope ? at_floor :
                    at_top)) begin
                compare_value_a <= buffer_a;
                compare_value_b <= buffer_b;
            end
        end
    end

    // Shared holding register for split writes and counter/capture reads
    always @(posedge clk_i) begin
        if (rst_i) begin
            holding <= `RST_BYTE;
        end else if (wr) begin
            case (adr_i)
                `OFS_COUNT_HIGH, `OFS_CAPTURE_HIGH,
                `OFS_COMPARE_A_HIGH, `OFS_COMPARE_B_HIGH:
                    holding <= wbyte;
                default: holding <= holding;
            endcase
        end else if (rd) begin
            case (adr_i)
                `OFS_COUNT_LOW: holding <= count_value[15:8];
                `OFS_CAPTURE_LOW: holding <= capture_value[15:8];
                default: holding <= holding;
            endcase
        end
    end

    // Control, flag and mask registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            timer_control_a <= `RST_BYTE;
            timer_control_b <= `RST_BYTE;
            timer_control_c <= `RST_BYTE;
            timer_mask_reg <= `RST_BYTE;
            timer_flag_reg <= `RST_BYTE;
        end else begin
            if (wr && adr_i == `OFS_CONTROL_A)
                timer_control_a <= wbyte;
            if (wr && adr_i == `OFS_CONTROL_B)
                timer_control_b <= wbyte;
            if (wr && adr_i == `OFS_CONTROL_C)
                timer_control_c <= wbyte;
            if (wr && adr_i == `OFS_MASK)
                timer_mask_reg <= wbyte & `FLAG_USED;
            // Write one to clear; a new event in that cycle wins
            if (wr && adr_i == `OFS_FLAG)
                timer_flag_reg <= (timer_flag_reg & ~wbyte) |
                    set_flags;
            else
                timer_flag_reg <= timer_flag_reg | set_flags;
        end
    end

    // Masked requests, one line per source
    assign request_o = {timer_flag_reg[`FL_CAPTURE],
        timer_flag_reg[`FL_CMP_B], timer_flag_reg[`FL_CMP_A],
        timer_flag_reg[`FL_OVERFLOW]} &
        {timer_mask_reg[`FL_CAPTURE], timer_mask_reg[`FL_CMP_B],
        timer_mask_reg[`FL_CMP_A], timer_mask_reg[`FL_OVERFLOW]};

    // Compare pins: toggle in non-PWM, set/clear in PWM modes.
    // Compare A as ceiling in PWM gives no waveform on pin A.
    always @(posedge clk_i) begin
        if (rst_i) begin
            compare_output_a_o <= 1'b0;
            compare_output_b_o <= 1'b0;
        end else if (timer_tick) begin
            if (timer_control_a[`CA_OUT_A] == 2'b00 ||
                    (pwm_mode && a_is_top))
                compare_output_a_o <= 1'b0;
            else if (!pwm_mode && match_a)
                compare_output_a_o <= ~compare_output_a_o;
            else if (pwm_mode && match_a)
                compare_output_a_o <= dual_slope & count_down;
            else if (pwm_mode && !dual_slope && at_top)
                compare_output_a_o <= 1'b1;
            if (timer_control_a[`CA_OUT_B] == 2'b00)
                compare_output_b_o <= 1'b0;
            else if (!pwm_mode && match_b)
                compare_output_b_o <= ~compare_output_b_o;
            else if (pwm_mode && match_b)
                compare_output_b_o <= dual_slope & count_down;
            else if (pwm_mode && !dual_slope && at_top)
                compare_output_b_o <= 1'b1;
        end
    end

    // Read mux; compare reads return the software-side buffer
    always @* begin
        case (adr_i)
            `OFS_CONTROL_A: rd_byte = timer_control_a;
            `OFS_CONTROL_B: rd_byte = timer_control_b;
            `OFS_CONTROL_C: rd_byte = timer_control_c;
            `OFS_COUNT_LOW: rd_byte = count_value[7:0];
            `OFS_COUNT_HIGH: rd_byte = holding;
            `OFS_CAPTURE_LOW: rd_byte = capture_value[7:0];
            `OFS_CAPTURE_HIGH: rd_byte = holding;
            `OFS_COMPARE_A_LOW: rd_byte = buffer_a[7:0];
            `OFS_COMPARE_A_HIGH: rd_byte = buffer_a[15:8];
            `OFS_COMPARE_B_LOW: rd_byte = buffer_b[7:0];
            `OFS_COMPARE_B_HIGH: rd_byte = buffer_b[15:8];
            `OFS_FLAG: rd_byte = timer_flag_reg;
            `OFS_MASK: rd_byte = timer_mask_reg;
            default: rd_byte = `RST_BYTE;
        endcase
    end

    // Bus answer: ack one cycle after the request, then drop
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= access;
            if (rd)
                dat_o <= {24'h000000, rd_byte};
        end
    end

endmodule // timer16_core

// ==== test/cpu_model.sv ====
// Processor stand-in: byte transfers over classic Wishbone.
// Assumes a slave that answers every request with one ack pulse.
`timescale 1ns/10ps
module cpu_model (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] rdat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    output logic timeout_o
);
    // Idle bus at time zero; only lane 0 carries data
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h1;
        dat_o = 32'h00000000;
        timeout_o = 1'b0;
    end

    // One transfer, held until ack is sampled; bounded wait
    task access(input logic wr, input logic [7:0] adr,
                input logic [7:0] wd, output logic [7:0] rd);
        int n;
        begin
            n = 0;
            @(posedge clk_i);
            cyc_o <= 1'b1;
            stb_o <= 1'b1;
            we_o <= wr;
            adr_o <= adr;
            dat_o <= {24'h000000, wd};
            do begin
                @(posedge clk_i);
                n = n + 1;
            end while (ack_i !== 1'b1 && n < 64);
            if (ack_i !== 1'b1)
                timeout_o <= 1'b1;
            rd = rdat_i[7:0];
            cyc_o <= 1'b0;
            stb_o <= 1'b0;
        end
    endtask

    // Split write: high byte first, never interleaved with others
    task wr16(input logic [7:0] hi, input logic [7:0] lo,
              input logic [15:0] v);
        logic [7:0] d;
        begin
            access(1'b1, hi, v[15:8], d);
            access(1'b1, lo, v[7:0], d);
        end
    endtask

    // Split read: low byte first so the high byte is frozen
    task rd16(input logic [7:0] lo, input logic [7:0] hi,
              output logic [15:0] v);
        begin
            access(1'b0, lo, 8'h00, v[7:0]);
            access(1'b0, hi, 8'h00, v[15:8]);
        end
    endtask
endmodule // cpu_model

// ==== test/timer16_core_properties.sv ====
// Checker for the timer core: bus handshake and reset-state relations.
// Sees only the core's ports; assumes a master that idles between cycles.
`timescale 1ns/10ps
module timer16_core_properties (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    input wire compare_output_a_o,
    input wire compare_output_b_o,
    input wire ceiling_o,
    input wire count_floor_o,
    input wire [3:0] request_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Handshake: one answer per request, one cycle wide
    AST_ACK_GAP: assert property (ack_o |=> !ack_o [*2])
        else $error("ack not a single pulse");
    AST_ACK_ANSWER: assert property ((cyc_i && stb_i && !ack_o)
        |=> ack_o) else $error("request not answered next cycle");
    AST_ACK_IDLE: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    // Byte-wide data path; unmapped reads give zero
    AST_READ_BYTE: assert property ((ack_o && !$past(we_i))
        |-> dat_o[31:8] == 24'h000000) else $error("upper read bits set");
    AST_UNMAPPED: assert property ((ack_o && !$past(we_i)
        && $past(adr_i) > 8'h30) |-> dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    // Read data only moves when a read is taken
    AST_DAT_HOLD: assert property (!(cyc_i && stb_i && !we_i && !ack_o)
        |=> $stable(dat_o)) else $error("read data moved");
    // Counter starts at zero, so floor and not ceiling
    AST_FLOOR_RESET: assert property ($fell(rst_i)
        |-> count_floor_o && !ceiling_o) else $error("limits after reset");
    AST_PINS_RESET: assert property ($fell(rst_i) |->
        !compare_output_a_o && !compare_output_b_o && request_o == 4'h0)
        else $error("pins after reset");
    // A cleared mask silences every request at once
    AST_MASK_OFF: assert property ((ack_o && $past(we_i)
        && $past(sel_i[0]) && $past(adr_i) == 8'h30
        && $past(dat_i[7:0]) == 8'h00) |-> request_o == 4'h0)
        else $error("request with mask cleared");
endmodule // timer16_core_properties

bind timer16_core timer16_core_properties timer16_core_properties_i (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .compare_output_a_o, .compare_output_b_o,
    .ceiling_o, .count_floor_o, .request_o);

// ==== test/timer16_core_tb.sv ====
// Self-checking bench for the timer core, driven through cpu_model.
// Assumes the design header with offsets and clock-select codes.
`timescale 1ns/10ps
`include "timer16_defs.vh"
module timer16_core_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc, stb, we, ack, tmo, oc_a, oc_b, ceil, flr;
    logic pin_ext = 1'b0;
    logic pin_cap = 1'b0;
    logic cmp_in = 1'b1;
    logic cmp_sel = 1'b0;
    logic [7:0] adr, b;
    logic [3:0] sel, req;
    logic [31:0] wdat, rdat;
    logic [15:0] w;
    int bad_count = 0;
    int checks = 0;

    timer16_core timer16_core_i (.clk_i(clk), .rst_i(rst), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .external_count_pin_i(pin_ext),
        .capture_pin_i(pin_cap), .comparator_i(cmp_in),
        .comparator_sel_i(cmp_sel), .compare_output_a_o(oc_a),
        .compare_output_b_o(oc_b), .ceiling_o(ceil),
        .count_floor_o(flr), .request_o(req));
    cpu_model cpu_model_i (.clk_i(clk), .ack_i(ack), .rdat_i(rdat),
        .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
        .dat_o(wdat), .timeout_o(tmo));

    // 125 MHz system clock
    always #4 clk = ~clk;

    task chk(input logic [15:0] got, input logic [15:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task end_of_test;
        begin
            $display("checks=%0d mismatches=%0d", checks, bad_count);
            if (bad_count == 0 && checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    // A bus wait that ran out ends the run as a failure
    always @(posedge tmo) begin
        bad_count = bad_count + 1;
        end_of_test;
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        cpu_model_i.access(1'b1, `OFS_CONTROL_C, 8'hA5, b);
        cpu_model_i.access(1'b0, `OFS_CONTROL_C, 8'h00, b);
        chk({8'h00, b}, 16'h00A5);
        cpu_model_i.access(1'b0, 8'h40, 8'h00, b);
        chk({8'h00, b}, 16'h0000);
        $display("test control done");
        // Stopped counter: split write then split read
        cpu_model_i.wr16(`OFS_COUNT_HIGH, `OFS_COUNT_LOW, 16'h01FF);
        cpu_model_i.rd16(`OFS_COUNT_LOW, `OFS_COUNT_HIGH, w);
        chk(w, 16'h01FF);
        // One high byte serves both compares; compare high bypasses it
        cpu_model_i.wr16(`OFS_COMPARE_A_HIGH, `OFS_COMPARE_A_LOW,
            16'h1234);
        cpu_model_i.access(1'b1, `OFS_COMPARE_B_LOW, 8'h56, b);
        cpu_model_i.access(1'b0, `OFS_COUNT_LOW, 8'h00, b);
        cpu_model_i.access(1'b0, `OFS_COMPARE_B_HIGH, 8'h00, b);
        chk({8'h00, b}, 16'h0012);
        cpu_model_i.access(1'b0, `OFS_COUNT_HIGH, 8'h00, b);
        chk({8'h00, b}, 16'h0001);
        cpu_model_i.rd16(`OFS_COMPARE_A_LOW, `OFS_COMPARE_A_HIGH, w);
        chk(w, 16'h1234);
        $display("test holding done");
        // Load while ticking every clock; reads are three cycles apart.
        // Normal mode has no counter-write hazard, so this write is safe.
        cpu_model_i.access(1'b1, `OFS_CONTROL_B, {5'h00, `CS_DIV1}, b);
        cpu_model_i.wr16(`OFS_COUNT_HIGH, `OFS_COUNT_LOW, 16'h0010);
        cpu_model_i.rd16(`OFS_COUNT_LOW, `OFS_COUNT_HIGH, w);
        chk(w, 16'h0012);
        cpu_model_i.access(1'b1, `OFS_CONTROL_B, 8'h00, b);
        cpu_model_i.wr16(`OFS_COUNT_HIGH, `OFS_COUNT_LOW, 16'hFFFF);
        chk({15'h0000, ceil}, 16'h0001);
        cpu_model_i.access(1'b1, `OFS_FLAG, 8'h27, b);
        cpu_model_i.access(1'b1, `OFS_CONTROL_B, {5'h00, `CS_DIV1}, b);
        cpu_model_i.access(1'b1, `OFS_CONTROL_B, 8'h00, b);
        cpu_model_i.access(1'b0, `OFS_FLAG, 8'h00, b);
        chk({8'h00, b}, 16'h0001);
        $display("test counting done");
        // Mask gates the overflow request; flag clears by writing one
        cpu_model_i.access(1'b1, `OFS_MASK, 8'h01, b);
        chk({12'h000, req}, 16'h0001);
        cpu_model_i.access(1'b1, `OFS_MASK, 8'hFF, b);
        cpu_model_i.access(1'b0, `OFS_MASK, 8'h00, b);
        chk({8'h00, b}, 16'h0027);
        cpu_model_i.access(1'b1, `OFS_FLAG, 8'h01, b);
        cpu_model_i.access(1'b0, `OFS_FLAG, 8'h00, b);
        chk({8'h00, b}, 16'h0000);
        cpu_model_i.access(1'b1, `OFS_MASK, 8'h00, b);
        $display("test flags done");
        // External rising edges are the only ticks
        cpu_model_i.wr16(`OFS_COUNT_HIGH, `OFS_COUNT_LOW, 16'h0000);
        chk({15'h0000, flr}, 16'h0001);
        cpu_model_i.access(1'b1, `OFS_CONTROL_B, {5'h00, `CS_EXT_RISE}, b);
        repeat (3) begin
            repeat (2) @(posedge clk);
            pin_ext <= 1'b1;
            repeat (2) @(posedge clk);
            pin_ext <= 1'b0;
        end
        repeat (4) @(posedge clk);
        cpu_model_i.access(1'b1, `OFS_CONTROL_B, 8'h00, b);
        cpu_model_i.rd16(`OFS_COUNT_LOW, `OFS_COUNT_HIGH, w);
        chk(w, 16'h0003);
        $display("test external clock done");
        // Rising capture edge stores the stopped count and sets its flag
        cpu_model_i.wr16(`OFS_COUNT_HIGH, `OFS_COUNT_LOW, 16'h0ABC);
        cpu_model_i.access(1'b1, `OFS_CONTROL_B, 8'h40, b);
        pin_cap <= 1'b1;
        repeat (4) @(posedge clk);
        cpu_model_i.rd16(`OFS_CAPTURE_LOW, `OFS_CAPTURE_HIGH, w);
        chk(w, 16'h0ABC);
        cpu_model_i.access(1'b0, `OFS_FLAG, 8'h00, b);
        chk({8'h00, b}, 16'h0020);
        $display("test capture done");
        // Mode 4: compare A is the ceiling; nine ticks from zero end at 3
        cpu_model_i.access(1'b1, `OFS_CONTROL_B, 8'h08, b);
        cpu_model_i.access(1'b1, `OFS_CONTROL_A, 8'h50, b);
        cpu_model_i.wr16(`OFS_COMPARE_A_HIGH, `OFS_COMPARE_A_LOW,
            16'h0005);
        cpu_model_i.access(1'b1, `OFS_COMPARE_B_LOW, 8'h03, b);
        cpu_model_i.access(1'b1, `OFS_COUNT_LOW, 8'h00, b);
        cpu_model_i.access(1'b1, `OFS_FLAG, 8'h27, b);
        cpu_model_i.access(1'b1, `OFS_CONTROL_B, 8'h09, b);
        repeat (6) @(posedge clk);
        cpu_model_i.access(1'b1, `OFS_CONTROL_B, 8'h08, b);
        chk({14'h0000, oc_a, oc_b}, 16'h0003);
        cpu_model_i.rd16(`OFS_COUNT_LOW, `OFS_COUNT_HIGH, w);
        chk(w, 16'h0003);
        cpu_model_i.access(1'b0, `OFS_FLAG, 8'h00, b);
        chk({8'h00, b}, 16'h0007);
        $display("test compare done");
        // Filtered comparator source: a two-sample dip must not capture
        cmp_sel <= 1'b1;
        cpu_model_i.wr16(`OFS_COUNT_HIGH, `OFS_COUNT_LOW, 16'h0055);
        cpu_model_i.access(1'b1, `OFS_FLAG, 8'h27, b);
        cpu_model_i.access(1'b1, `OFS_CONTROL_B, 8'h80, b);
        cmp_in <= 1'b0;
        repeat (2) @(posedge clk);
        cmp_in <= 1'b1;
        repeat (8) @(posedge clk);
        cpu_model_i.access(1'b0, `OFS_FLAG, 8'h00, b);
        chk({8'h00, b}, 16'h0000);
        cmp_in <= 1'b0;
        repeat (8) @(posedge clk);
        cpu_model_i.rd16(`OFS_CAPTURE_LOW, `OFS_CAPTURE_HIGH, w);
        chk(w, 16'h0055);
        $display("test comparator done");
        end_of_test;
    end
endmodule // timer16_core_tb
